// ===== dv/abe_block_enable_tb.sv
// Self-checking bench for the block enable bits
// Assumes abe_pkg and abe_block_enable are compiled first
module abe_block_enable_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import abe_pkg::*;
   logic mclk, rst_n, cfg_wr, temp_conv_done, temp_conv_start, temp_result_valid;
   logic [14:0] cfg_wdata, cfg_rdata;
   logic [15:0] temp_conv_value, temp_result_data;
   abe_ctrl_t ctrl;
   int fail_count = 0;
   int compares = 0;
   abe_block_enable i_dut (.mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .temp_conv_start(temp_conv_start),
      .temp_conv_done(temp_conv_done), .temp_conv_value(temp_conv_value),
      .temp_result_data(temp_result_data), .temp_result_valid(temp_result_valid),
      .ctrl(ctrl));
   // ------------------------------------------------------------
   // Clock and helpers
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [14:0] v);
      @(negedge mclk);
      cfg_wr = 1'b1;
      cfg_wdata = v;
      @(negedge mclk);
      cfg_wr = 1'b0;
   endtask
   task automatic done_pulse(input logic [15:0] v);
      temp_conv_done = 1'b1;
      temp_conv_value = v;
      @(negedge mclk);
      temp_conv_done = 1'b0;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_fields();
      logic [14:0] v;
      for (int b = 0; b < 16; b++) begin
         v = (b == 15) ? 15'h6FFF : 15'h0001 << b;
         wr(v);
         chk("rdata", {1'b0, v & 15'h7FE0}, {1'b0, cfg_rdata});
         chk("ctrl", {6'h00, v[14], v[12], v[13], v[11], v[10], v[9], v[7], v[7] & v[8],
            v[6], v[5]}, {6'h00, ctrl});
         chk("start", 16'h0000, {15'h0000, temp_conv_start});
      end
      wr(15'h0000);
   endtask
   task automatic test_convert();
      wr(15'h3000);
      chk("start", 16'h0001, {15'h0000, temp_conv_start});
      @(negedge mclk);
      chk("start_busy", 16'h0000, {15'h0000, temp_conv_start});
      done_pulse(16'hA5C3);
      chk("result", 16'hA5C3, temp_result_data);
      chk("valid", 16'h0001, {15'h0000, temp_result_valid});
      chk("rdata_done", 16'h1000, {1'b0, cfg_rdata});
      @(negedge mclk);
      chk("valid_end", 16'h0000, {15'h0000, temp_result_valid});
      chk("start_again", 16'h0000, {15'h0000, temp_conv_start});
   endtask
   task automatic test_abort();
      wr(15'h3000);
      wr(15'h2000);
      chk("start_off", 16'h0000, {15'h0000, temp_conv_start});
      @(negedge mclk);
      done_pulse(16'h1234);
      chk("valid_abort", 16'h0000, {15'h0000, temp_result_valid});
      chk("result_kept", 16'hA5C3, temp_result_data);
      wr(15'h0000);
      done_pulse(16'h5678);
      chk("valid_idle", 16'h0000, {15'h0000, temp_result_valid});
   endtask
   task automatic test_rewrite();
      wr(15'h3000);
      @(negedge mclk);
      cfg_wr = 1'b1;
      cfg_wdata = 15'h3000;
      done_pulse(16'h0F0F);
      cfg_wr = 1'b0;
      chk("rdata_rewrite", 16'h3000, {1'b0, cfg_rdata});
      chk("result_rewrite", 16'h0F0F, temp_result_data);
      chk("start_rewrite", 16'h0001, {15'h0000, temp_conv_start});
      @(negedge mclk);
      done_pulse(16'h00F0);
      chk("result_second", 16'h00F0, temp_result_data);
      chk("rdata_cleared", 16'h1000, {1'b0, cfg_rdata});
   endtask
   task automatic print_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      cfg_wr = 1'b0;
      cfg_wdata = 15'h0000;
      temp_conv_done = 1'b0;
      temp_conv_value = 16'h0000;
      repeat (10) @(negedge mclk);
      chk("rst_rdata", 16'h0000, {1'b0, cfg_rdata});
      chk("rst_ctrl", 16'h0000, {6'h00, ctrl});
      rst_n = 1'b1;
      test_fields();
      test_convert();
      test_abort();
      test_rewrite();
      print_verdict();
   end
endmodule

// ===== hw/abe_block_enable.sv
// Block enable half of the front end configuration register
// Assumes writes and temperature results come from same-clock logic
module abe_block_enable (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register access
   input wire logic cfg_wr,
   input wire logic [14:0] cfg_wdata,
   output logic [14:0] cfg_rdata,
   // Temperature conversion handshake
   output logic temp_conv_start,
   input wire logic temp_conv_done,
   input wire logic [abe_pkg::ABE_TEMP_WIDTH-1:0] temp_conv_value,
   output logic [abe_pkg::ABE_TEMP_WIDTH-1:0] temp_result_data,
   output logic temp_result_valid,
   // Block controls
   output abe_pkg::abe_ctrl_t ctrl
);
   import abe_pkg::*;

   abe_state_t s_q;
   abe_state_t s_d;
   logic conv_fire;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      conv_fire = 1'b0;
      s_d.temp_done = 1'b0;
      if (cfg_wr) begin
         s_d.cfg = cfg_wdata & ABE_WRITE_MASK;
      end
      case (s_q.tstate)
         ABE_T_IDLE: begin
            if (s_q.cfg[ABE_BIT_TCONV] && s_q.cfg[ABE_BIT_TSENS]) begin
               conv_fire = 1'b1;
               s_d.tstate = ABE_T_BUSY;
            end
         end
         ABE_T_BUSY: begin
            if (temp_conv_done) begin
               s_d.temp_result_data = temp_conv_value;
               s_d.temp_done = 1'b1;
               s_d.tstate = ABE_T_IDLE;
               if (!(cfg_wr && cfg_wdata[ABE_BIT_TCONV])) begin
                  s_d.cfg[ABE_BIT_TCONV] = 1'b0;
               end
            end else if (!s_q.cfg[ABE_BIT_TSENS]) begin
               s_d.tstate = ABE_T_IDLE;
            end
         end
         default: begin
            s_d.tstate = ABE_T_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_q.cfg <= ABE_RESET_VALUE;
         s_q.tstate <= ABE_T_IDLE;
         s_q.temp_result_data <= ABE_TEMP_RESET;
         s_q.temp_done <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign cfg_rdata = s_q.cfg;
   assign temp_conv_start = conv_fire;
   assign temp_result_data = s_q.temp_result_data;
   assign temp_result_valid = s_q.temp_done;
   assign ctrl.wavegen_enable = s_q.cfg[ABE_BIT_WAVEGEN];
   assign ctrl.temp_sensor_power = s_q.cfg[ABE_BIT_TSENS];
   assign ctrl.temp_convert_req = s_q.cfg[ABE_BIT_TCONV];
   assign ctrl.hs_transimpedance_enable = s_q.cfg[ABE_BIT_TIA];
   assign ctrl.excitation_inst_amp_enable = s_q.cfg[ABE_BIT_INAMP];
   assign ctrl.excitation_buffer_enable = s_q.cfg[ABE_BIT_EXBUF];
   assign ctrl.converter_power = s_q.cfg[ABE_BIT_CPWR];
   assign ctrl.converter_run = s_q.cfg[ABE_BIT_CPWR] & s_q.cfg[ABE_BIT_CRUN];
   assign ctrl.hs_dac_path_enable = s_q.cfg[ABE_BIT_DAC];
   assign ctrl.high_power_ref_powerdown = s_q.cfg[ABE_BIT_REFPD];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_WAVEGEN: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_wr |=> ctrl.wavegen_enable == $past(cfg_wdata[14]))
      else $error("wavegen enable does not follow write");
   AST_TEMP_STORE: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.tstate == ABE_T_BUSY && temp_conv_done) |=>
      (temp_result_data == $past(temp_conv_value) && temp_result_valid))
      else $error("temperature result not stored");
   AST_TEMP_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
      temp_conv_start |-> (cfg_rdata[13] && cfg_rdata[12]))
      else $error("conversion started without sensor and start bit");
   AST_TIA: assert property (@(posedge mclk) disable iff (!rst_n)
      ctrl.hs_transimpedance_enable == cfg_rdata[11])
      else $error("transimpedance enable mismatch");
   AST_INAMP: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_wr |=> ctrl.excitation_inst_amp_enable == $past(cfg_wdata[10]))
      else $error("inst amp enable does not follow write");
   AST_EXBUF: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_wr |=> ctrl.excitation_buffer_enable == $past(cfg_wdata[9]))
      else $error("excitation buffer does not follow write");
   AST_RUN: assert property (@(posedge mclk) disable iff (!rst_n)
      ctrl.converter_run |-> (cfg_rdata[8] && ctrl.converter_power))
      else $error("converter runs without run and power bits");
   AST_PWR: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_wr |=> ctrl.converter_power == $past(cfg_wdata[7]))
      else $error("converter power does not follow write");
   AST_DAC: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_wr |=> (ctrl.hs_dac_path_enable == $past(cfg_wdata[6])
      && ctrl.wavegen_enable == $past(cfg_wdata[14])))
      else $error("dac path enable mismatch");
   AST_REFPD: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_wr |=> ctrl.high_power_ref_powerdown == $past(cfg_wdata[5]))
      else $error("reference powerdown does not follow write");
   AST_RSVD: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_rdata[4:0] == 5'h00)
      else $error("reserved bits not zero");

   // ------------------------------------------------------------
   // Register checks
   // ------------------------------------------------------------
   AST_RESET_STATE: assert property (@(posedge mclk)
      !rst_n |=>
      (cfg_rdata == ABE_RESET_VALUE && temp_result_data == ABE_TEMP_RESET && ctrl == '0))
      else $error("state not cleared by reset");
   AST_CFG_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_wr |=>
      cfg_rdata == ($past(cfg_wdata) & ABE_WRITE_MASK))
      else $error("readback does not follow masked write");
   AST_CFG_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (!cfg_wr && !(s_q.tstate == ABE_T_BUSY && temp_conv_done)) |=>
      $stable(cfg_rdata))
      else $error("register changed without write or completion");
   AST_WAVEGEN_LVL: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |->
      ctrl.wavegen_enable == cfg_rdata[ABE_BIT_WAVEGEN])
      else $error("wavegen enable level mismatch");
   AST_TSENS_LVL: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |->
      ctrl.temp_sensor_power == cfg_rdata[ABE_BIT_TSENS])
      else $error("sensor power level mismatch");
   AST_TSENS_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_wr |=>
      ctrl.temp_sensor_power == $past(cfg_wdata[ABE_BIT_TSENS]))
      else $error("sensor power does not follow write");
   AST_TIA_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_wr |=>
      ctrl.hs_transimpedance_enable == $past(cfg_wdata[ABE_BIT_TIA]))
      else $error("transimpedance enable does not follow write");
   AST_INAMP_LVL: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |->
      ctrl.excitation_inst_amp_enable == cfg_rdata[ABE_BIT_INAMP])
      else $error("inst amp enable level mismatch");
   AST_EXBUF_LVL: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |->
      ctrl.excitation_buffer_enable == cfg_rdata[ABE_BIT_EXBUF])
      else $error("excitation buffer level mismatch");
   AST_RUN_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_wr |=>
      ctrl.converter_run == ($past(cfg_wdata[ABE_BIT_CRUN]) && $past(cfg_wdata[ABE_BIT_CPWR])))
      else $error("converter run does not follow write");
   AST_PWR_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
      (cfg_rdata[ABE_BIT_CPWR] && !cfg_rdata[ABE_BIT_CRUN]) |->
      (ctrl.converter_power && !ctrl.converter_run))
      else $error("powered converter runs without run bit");
   AST_PWR_LVL: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |->
      ctrl.converter_power == cfg_rdata[ABE_BIT_CPWR])
      else $error("converter power level mismatch");
   AST_DAC_LVL: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |->
      ctrl.hs_dac_path_enable == cfg_rdata[ABE_BIT_DAC])
      else $error("dac path level mismatch");
   AST_DAC_ALONE: assert property (@(posedge mclk) disable iff (!rst_n)
      (cfg_rdata[ABE_BIT_DAC] && !cfg_rdata[ABE_BIT_WAVEGEN]) |->
      (ctrl.hs_dac_path_enable && !ctrl.wavegen_enable))
      else $error("dac path enable drives wavegen");
   AST_REFPD_LVL: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |->
      ctrl.high_power_ref_powerdown == cfg_rdata[ABE_BIT_REFPD])
      else $error("reference powerdown level mismatch");

   // ------------------------------------------------------------
   // Conversion checks
   // ------------------------------------------------------------
   AST_TCONV_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.tstate == ABE_T_BUSY && temp_conv_done && !cfg_wr) |=>
      !cfg_rdata[ABE_BIT_TCONV])
      else $error("start bit not cleared on completion");
   AST_TCONV_WIN: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.tstate == ABE_T_BUSY && temp_conv_done && cfg_wr && cfg_wdata[ABE_BIT_TCONV]) |=>
      cfg_rdata[ABE_BIT_TCONV])
      else $error("write of start bit lost at completion");
   AST_DONE_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.tstate == ABE_T_IDLE && temp_conv_done) |=>
      (!temp_result_valid && $stable(temp_result_data)))
      else $error("completion taken while idle");
   AST_RESULT_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      !(s_q.tstate == ABE_T_BUSY && temp_conv_done) |=>
      $stable(temp_result_data))
      else $error("result changed without completion");
   AST_VALID_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
      temp_result_valid |=>
      !temp_result_valid)
      else $error("result valid longer than one cycle");
   AST_START_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
      temp_conv_start |=>
      (!temp_conv_start && s_q.tstate == ABE_T_BUSY))
      else $error("start not a single pulse into busy");
   AST_START_WHEN: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.tstate == ABE_T_IDLE && cfg_rdata[ABE_BIT_TCONV] && cfg_rdata[ABE_BIT_TSENS]) |->
      temp_conv_start)
      else $error("requested conversion not started");
   AST_BUSY_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.tstate == ABE_T_BUSY && !temp_conv_done && cfg_rdata[ABE_BIT_TSENS]) |=>
      s_q.tstate == ABE_T_BUSY)
      else $error("conversion left busy without completion");
   AST_ABORT: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.tstate == ABE_T_BUSY && !temp_conv_done && !cfg_rdata[ABE_BIT_TSENS]) |=>
      (s_q.tstate == ABE_T_IDLE && !temp_result_valid))
      else $error("conversion not dropped on sensor power down");
   AST_START_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
      (!cfg_rdata[ABE_BIT_TSENS] || !cfg_rdata[ABE_BIT_TCONV]) |->
      !temp_conv_start)
      else $error("start without sensor power and start bit");
endmodule

// ===== hw/abe_pkg.sv
// Constants and carriers for the front end block enable bits
// Assumes a single clock and a synchronous active-low reset
//
// Behaviour
// - Bit 14 runs the waveform generator
// - Bit 13 starts one conversion when bit 12 is set, result stored
// - Bit 12 powers sensor; reads need bit 13
// - Bit 11 enables transimpedance amplifier
// - Bit 10 enables instrumentation amplifier
// - Bit 9 enables excitation buffer
// - Bit 8 zero keeps converter idle
// - Bit 7 powers converter; run needs bit 8
// - Bit 6 enables only DAC analog path
// - Bit 5 high powers down the reference
package abe_pkg;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ABE_WIDTH = 15;
   localparam int ABE_BIT_WAVEGEN = 14;
   localparam int ABE_BIT_TCONV = 13;
   localparam int ABE_BIT_TSENS = 12;
   localparam int ABE_BIT_TIA = 11;
   localparam int ABE_BIT_INAMP = 10;
   localparam int ABE_BIT_EXBUF = 9;
   localparam int ABE_BIT_CRUN = 8;
   localparam int ABE_BIT_CPWR = 7;
   localparam int ABE_BIT_DAC = 6;
   localparam int ABE_BIT_REFPD = 5;
   localparam logic [14:0] ABE_WRITE_MASK = 15'h7FE0;
   localparam logic [14:0] ABE_RESET_VALUE = 15'h0000;
   localparam int ABE_TEMP_WIDTH = 16;
   localparam logic [15:0] ABE_TEMP_RESET = 16'h0000;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ABE_T_IDLE = 2'b00,
      ABE_T_BUSY = 2'b01
   } abe_tstate_t;

   typedef struct packed {
      logic wavegen_enable;
      logic temp_sensor_power;
      logic temp_convert_req;
      logic hs_transimpedance_enable;
      logic excitation_inst_amp_enable;
      logic excitation_buffer_enable;
      logic converter_power;
      logic converter_run;
      logic hs_dac_path_enable;
      logic high_power_ref_powerdown;
   } abe_ctrl_t;

   typedef struct packed {
      logic [14:0] cfg;
      abe_tstate_t tstate;
      logic [15:0] temp_result_data;
      logic temp_done;
   } abe_state_t;
endpackage
